// >>> core/fcw_defs.vh
/*
 * Constants of the frequency counter window block: register offsets,
 * control field positions, reset values, source codes and limits.
 * Assumes it is included by bare name from the design files.
 */
`ifndef FCW_DEFS_VH
`define FCW_DEFS_VH

// ----------------------------------------------------------------
// Register offsets on the special function register port
// ----------------------------------------------------------------
`define FCW_ADDR_CTRL 8'h9c
`define FCW_ADDR_LEN 8'h9d
`define FCW_ADDR_CNT0 8'h9e
`define FCW_ADDR_CNT1 8'h9f
`define FCW_ADDR_CNT2 8'ha0

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define FCW_BIT_DONE 7
`define FCW_BIT_BUSY 6
`define FCW_BIT_DIVSEL 5
`define FCW_MODE_HI 2
`define FCW_MODE_LO 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FCW_RST_MODE 3'h0
`define FCW_RST_LEN 6'h00
`define FCW_RST_DIVSEL 1'b0

// ----------------------------------------------------------------
// Window source codes
// ----------------------------------------------------------------
`define FCW_SRC_OFF 3'h0
`define FCW_SRC_GPIO 3'h1
`define FCW_SRC_RCOSC 3'h2
`define FCW_SRC_SYSDIV 3'h3
`define FCW_SRC_XO 3'h4
`define FCW_SRC_TMUX 3'h5
`define FCW_SRC_TIMER 3'h6
`define FCW_SRC_PULSE 3'h7

// ----------------------------------------------------------------
// Window length limits
// ----------------------------------------------------------------
`define FCW_LEN_MAX 6'h2b
`define FCW_LEN_BASE 23'h000002
`define FCW_LEN_FORCED 23'h000001

`endif

// >>> core/fcw_sync.v
/*
 * Two-stage synchroniser for a group of asynchronous inputs.
 * Assumes each input is a level from outside the clk_sys domain.
 */
`timescale 1ns/1ps

module fcw_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_r <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // fcw_sync

// >>> core/fcw_counter.v
/*
 * Frequency counter window: counts edges of a high-frequency clock
 * during a window of reference clock cycles, or during a GPIO pulse.
 * Assumes all clock sources arrive as asynchronous levels, sampled on
 * clk_sys; a source must toggle slower than a quarter of clk_sys to be
 * seen edge for edge, so fast clocks are expected pre-divided.
 */
`timescale 1ns/1ps
`include "fcw_defs.vh"

// Overview of operation
// - The window lasts (2 + length bit 0) times two to the power of length bits 5..1 reference cycles.
// - A length value above 43 forces the window to exactly one reference cycle.
// - Source code zero switches the counter off and gates its clock so nothing is counted.
// - Source codes 1 to 6 pick GPIO, RC oscillator, divided system clock, crystal, test selector, timer.
// - Source code 7 counts the fast clock from rising to falling edge of a GPIO sensing pulse.
// - Writing one to the active bit with a nonzero source code starts a count, a further one restarts it, and reads show one while busy.
// - The active bit falling sets a level done flag, cleared by software or a new start, and settable by writes.
// - The divider select bit routes the VCO path on zero or the PLL path on one, both idle while off.
// - The counter counts fast clock edges during the window, giving the ratio of fast to reference clock.
module fcw_counter #(
    parameter CNT_W = 24
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Special function register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // Window reference sources, asynchronous
    input wire ref_gpio_clk,
    input wire main_rc_oscillator_clk,
    input wire sys_div_clk,
    input wire crystal_oscillator_clock,
    input wire test_mux_out,
    input wire timer_out,
    input wire pulse_gpio,
    // Counted high-frequency clock, asynchronous
    input wire hf_clk,
    // Analog controls and status
    output reg inductor_vco_path_sel,
    output reg mpll_path_en,
    output reg counter_clock_en,
    output reg count_finished_flag
);

    // ----------------------------------------------------------------
    // State encoding
    // ----------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_ARM = 3'b010;
    localparam ST_COUNT = 3'b100;

    // ----------------------------------------------------------------
    // Window length function
    // ----------------------------------------------------------------
    // window formula
    function [22:0] win_len;
        input [5:0] len;
        begin
            if (len > `FCW_LEN_MAX)
                win_len = `FCW_LEN_FORCED;
            else
                win_len = (`FCW_LEN_BASE + {22'h000000, len[0]}) << len[5:1];
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    wire [7:0] sync_w;
    reg [7:0] sync_d_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [2:0] mode_r;
    reg divsel_r;
    reg [5:0] len_r;
    reg done_r;
    reg done_nxt;
    reg [22:0] ref_cnt_r;
    reg [22:0] ref_cnt_nxt;
    reg [CNT_W-1:0] hf_cnt_r;
    reg [CNT_W-1:0] hf_cnt_nxt;
    reg ref_lvl;
    reg ref_prev;
    wire wr_ctrl;
    wire wr_len;
    wire start;
    wire busy;
    wire ref_rise;
    wire pulse_rise;
    wire pulse_fall;
    wire hf_rise;
    wire busy_fall;
    wire [CNT_W+7:0] cnt_ext;

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    fcw_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({hf_clk, pulse_gpio, timer_out, test_mux_out,
                   crystal_oscillator_clock, sys_div_clk,
                   main_rc_oscillator_clk, ref_gpio_clk}),
        .sync_out(sync_w)
    );

    // Delayed copy of synchronised levels for edge detection
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_d_r <= 8'h00;
        end else begin
            sync_d_r <= sync_w;
        end
    end

    always @* begin
        ref_lvl = 1'b0;
        ref_prev = 1'b0;
        case (mode_r)
            `FCW_SRC_GPIO: begin
                ref_lvl = sync_w[0];
                ref_prev = sync_d_r[0];
            end
            `FCW_SRC_RCOSC: begin
                ref_lvl = sync_w[1];
                ref_prev = sync_d_r[1];
            end
            `FCW_SRC_SYSDIV: begin
                ref_lvl = sync_w[2];
                ref_prev = sync_d_r[2];
            end
            `FCW_SRC_XO: begin
                ref_lvl = sync_w[3];
                ref_prev = sync_d_r[3];
            end
            `FCW_SRC_TMUX: begin
                ref_lvl = sync_w[4];
                ref_prev = sync_d_r[4];
            end
            `FCW_SRC_TIMER: begin
                ref_lvl = sync_w[5];
                ref_prev = sync_d_r[5];
            end
            default: begin
                ref_lvl = 1'b0;
                ref_prev = 1'b0;
            end
        endcase
    end

    // Edge strobes, all from second stage onward
    assign ref_rise = ref_lvl & ~ref_prev;
    assign pulse_rise = sync_w[6] & ~sync_d_r[6];
    assign pulse_fall = ~sync_w[6] & sync_d_r[6];
    assign hf_rise = sync_w[7] & ~sync_d_r[7];

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    assign wr_ctrl = sfr_wr & (sfr_addr == `FCW_ADDR_CTRL);
    assign wr_len = sfr_wr & (sfr_addr == `FCW_ADDR_LEN);
    assign start = wr_ctrl & sfr_wdata[`FCW_BIT_BUSY] & (sfr_wdata[`FCW_MODE_HI:`FCW_MODE_LO] != `FCW_SRC_OFF);
    assign busy = (state_r != ST_IDLE);

    // Mode, divider select and window length storage
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_r <= `FCW_RST_MODE;
            divsel_r <= `FCW_RST_DIVSEL;
            len_r <= `FCW_RST_LEN;
        end else begin
            if (wr_ctrl) begin
                mode_r <= sfr_wdata[`FCW_MODE_HI:`FCW_MODE_LO];
                divsel_r <= sfr_wdata[`FCW_BIT_DIVSEL];
            end
            if (wr_len)
                len_r <= sfr_wdata[5:0];
        end
    end

    // ----------------------------------------------------------------
    // Window sequencer
    // ----------------------------------------------------------------
    // Sequencer waits for a first reference edge so the window spans whole cycles
    always @* begin
        state_nxt = state_r;
        ref_cnt_nxt = ref_cnt_r;
        hf_cnt_nxt = hf_cnt_r;
        case (state_r)
            ST_IDLE: begin
                state_nxt = ST_IDLE;
            end
            ST_ARM: begin
                if (mode_r == `FCW_SRC_PULSE) begin
                    if (pulse_rise)
                        state_nxt = ST_COUNT;
                end else if (ref_rise) begin
                    state_nxt = ST_COUNT;
                    ref_cnt_nxt = 23'h000000;
                end
            end
            ST_COUNT: begin
                if (hf_rise)
                    hf_cnt_nxt = hf_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                if (mode_r == `FCW_SRC_PULSE) begin
                    if (pulse_fall)
                        state_nxt = ST_IDLE;
                end else if (ref_rise) begin
                    ref_cnt_nxt = ref_cnt_r + 23'h000001;
                    if (ref_cnt_nxt == win_len(len_r))
                        state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (start) begin
            state_nxt = ST_ARM;
            ref_cnt_nxt = 23'h000000;
            hf_cnt_nxt = {CNT_W{1'b0}};
        end
        if (mode_r == `FCW_SRC_OFF && !start)
            state_nxt = ST_IDLE;
    end

    assign busy_fall = busy & (state_nxt == ST_IDLE);

    // done flag, hardware set wins over any clear
    always @* begin
        done_nxt = done_r;
        if (wr_ctrl)
            done_nxt = sfr_wdata[`FCW_BIT_DONE] & ~start;
        if (busy_fall)
            done_nxt = 1'b1;
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            ref_cnt_r <= 23'h000000;
            hf_cnt_r <= {CNT_W{1'b0}};
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ref_cnt_r <= ref_cnt_nxt;
            hf_cnt_r <= hf_cnt_nxt;
            done_r <= done_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs and read data
    // ----------------------------------------------------------------
    assign cnt_ext = {8'h00, hf_cnt_r};

    // Registered outputs; analog controls idle while off
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            inductor_vco_path_sel <= 1'b0;
            mpll_path_en <= 1'b0;
            counter_clock_en <= 1'b0;
            count_finished_flag <= 1'b0;
            sfr_rdata <= 8'h00;
        end else begin
            inductor_vco_path_sel <= (mode_r != `FCW_SRC_OFF) & ~divsel_r;
            mpll_path_en <= (mode_r != `FCW_SRC_OFF) & divsel_r;
            counter_clock_en <= (mode_r != `FCW_SRC_OFF);
            count_finished_flag <= done_nxt;
            if (sfr_rd) begin
                case (sfr_addr)
                    `FCW_ADDR_CTRL: sfr_rdata <= {done_r, busy, divsel_r, 2'b00, mode_r};
                    `FCW_ADDR_LEN: sfr_rdata <= {2'b00, len_r};
                    `FCW_ADDR_CNT0: sfr_rdata <= cnt_ext[7:0];
                    `FCW_ADDR_CNT1: sfr_rdata <= cnt_ext[15:8];
                    `FCW_ADDR_CNT2: sfr_rdata <= cnt_ext[23:16];
                    default: sfr_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // fcw_counter

// >>> test/fcw_counter_asserts.sv
/*
 * Checker for the frequency counter window: register port, path controls
 * and done flag. Sees only the ports of fcw_counter; bound at the foot.
 */
`timescale 1ns/1ps
`include "fcw_defs.vh"

module fcw_checker (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    // Controls and status
    input wire inductor_vco_path_sel,
    input wire mpll_path_en,
    input wire counter_clock_en,
    input wire count_finished_flag
);
    // Control register accesses
    wire ctrl_wr = sfr_wr && sfr_addr == `FCW_ADDR_CTRL;
    wire ctrl_rd = sfr_rd && sfr_addr == `FCW_ADDR_CTRL;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Start with a live mode, and start with mode zero
    sequence s_start;
        ctrl_wr && sfr_wdata[6] && sfr_wdata[2:0] != 3'h0;
    endsequence
    sequence s_off_start;
        ctrl_wr && sfr_wdata[6] && sfr_wdata[2:0] == 3'h0;
    endsequence

    // Path controls, busy readback and done flag
    // Path controls trail a control write by two edges: mode register, then output flop
    clock_gated_a: assert property (ctrl_wr && sfr_wdata[2:0] == 3'h0
        |=> ##1 !counter_clock_en && !inductor_vco_path_sel && !mpll_path_en) else $error("clock not gated");
    start_refused_a: assert property (s_off_start ##1 !ctrl_wr ##1 ctrl_rd
        |=> !sfr_rdata[6]) else $error("mode zero start taken");
    vco_route_a: assert property (ctrl_wr && sfr_wdata[2:0] != 3'h0 && !sfr_wdata[5]
        |=> ##1 inductor_vco_path_sel && !mpll_path_en) else $error("vco path wrong");
    pll_route_a: assert property (ctrl_wr && sfr_wdata[2:0] != 3'h0 && sfr_wdata[5]
        |=> ##1 mpll_path_en && !inductor_vco_path_sel) else $error("pll path wrong");
    paths_match_a: assert property (counter_clock_en == (inductor_vco_path_sel || mpll_path_en)
        && !(inductor_vco_path_sel && mpll_path_en)) else $error("path controls disagree");
    busy_read_a: assert property (s_start ##1 !ctrl_wr ##1 ctrl_rd
        |=> sfr_rdata[6] && !sfr_rdata[7]) else $error("busy not shown");
    start_clears_a: assert property (s_start |=> !count_finished_flag) else $error("start kept done");
    done_force_a: assert property (ctrl_wr && sfr_wdata[7] && !sfr_wdata[6]
        |=> count_finished_flag) else $error("done not forced");
    done_holds_a: assert property (count_finished_flag && !ctrl_wr
        |=> count_finished_flag) else $error("done dropped");
    rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
    len_field_a: assert property (sfr_rd && sfr_addr == `FCW_ADDR_LEN
        |=> sfr_rdata[7:6] == 2'b00) else $error("length high bits set");
endmodule // fcw_checker

bind fcw_counter fcw_checker i_chk (
    .clk_sys(clk_sys),
    .rst(rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .inductor_vco_path_sel(inductor_vco_path_sel),
    .mpll_path_en(mpll_path_en),
    .counter_clock_en(counter_clock_en),
    .count_finished_flag(count_finished_flag)
);

// >>> test/fcw_sources.sv
/*
 * Far-side clock sources: six reference lines, a sensing pulse and the
 * fast counted clock. Free running and unrelated to clk_sys.
 */
`timescale 1ns/1ps

module fcw_sources (
    // Source choice from the bench
    input wire [2:0] src,
    // Path controls from the block
    input wire vco_on,
    input wire pll_on,
    // Clocks towards the block
    output wire [6:1] ref_clk,
    output reg pulse_gpio,
    output wire hf_clk
);
    reg ref_ph = 1'b0;
    reg hf_ph = 1'b0;

    // Reference 800 ns, fast 200 ns; fast rises sit 100 ns off the reference rise
    initial begin
        pulse_gpio = 1'b0;
        #13;
        forever #400 ref_ph = ~ref_ph;
    end
    initial begin
        #13;
        forever #100 hf_ph = ~hf_ph;
    end

    assign ref_clk = (src != 3'h0 && src != 3'h7) ? {5'h00, ref_ph} << (src - 3'h1) : 6'h00;
    // fast clock only with a path on
    assign hf_clk = hf_ph && (vco_on || pll_on);

    // single pulse line, k fast rises inside
    task send_pulse(input integer k);
        begin
            @(posedge hf_ph);
            #100 pulse_gpio = 1'b1;
            #(200 * k) pulse_gpio = 1'b0;
        end
    endtask
endmodule // fcw_sources

// >>> test/frequency_counter_window_tb.sv
/*
 * Self-checking bench for fcw_counter with fcw_sources on the far side.
 * Assumes the checker is bound in and fcw_defs.vh is on the include path.
 */
`timescale 1ns/1ps
`include "fcw_defs.vh"

module frequency_counter_window_tb;
    reg clk_sys, rst, sfr_wr, sfr_rd;
    reg [7:0] sfr_addr, sfr_wdata;
    reg [2:0] src;
    wire [7:0] sfr_rdata;
    wire [6:1] refs;
    wire pulse, hf, vco, pll, clken, done;
    integer mismatches, checks_done;

    fcw_counter i_dut (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ref_gpio_clk(refs[1]), .main_rc_oscillator_clk(refs[2]),
        .sys_div_clk(refs[3]), .crystal_oscillator_clock(refs[4]), .test_mux_out(refs[5]), .timer_out(refs[6]),
        .pulse_gpio(pulse), .hf_clk(hf), .inductor_vco_path_sel(vco), .mpll_path_en(pll),
        .counter_clock_en(clken), .count_finished_flag(done));
    fcw_sources i_src (.src(src), .vco_on(vco), .pll_on(pll), .ref_clk(refs), .pulse_gpio(pulse), .hf_clk(hf));

    // Comparison, bus cycles and helpers
    task check(input [23:0] seen, input [23:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            sfr_addr <= a;
            sfr_wdata <= d;
            sfr_wr <= 1'b1;
            @(posedge clk_sys);
            sfr_wr <= 1'b0;
            #1;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge clk_sys);
            sfr_addr <= a;
            sfr_rd <= 1'b1;
            @(posedge clk_sys);
            sfr_rd <= 1'b0;
            #1;
            d = sfr_rdata;
        end
    endtask
    task rd_cnt(output [23:0] c);
        begin
            rd(`FCW_ADDR_CNT0, c[7:0]);
            rd(`FCW_ADDR_CNT1, c[15:8]);
            rd(`FCW_ADDR_CNT2, c[23:16]);
        end
    endtask
    task wait_done;
        integer i;
        begin
            for (i = 0; i < 2000 && done !== 1'b1; i = i + 1)
                @(posedge clk_sys);
            #1;
            // A window that never closes counts as a mismatch
            if (done !== 1'b1) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t done never set", $time);
            end
        end
    endtask
    // Window length in reference cycles; above 43 it collapses to one
    function [23:0] n_of(input [5:0] l);
        n_of = (l > 6'd43) ? 24'h1 : ((24'h2 + l[0]) << l[5:1]);
    endfunction

    // Reset values, read-only and unmapped places, path routing, forced done
    task t_regs;
        reg [7:0] d;
        begin
            check({vco, pll, clken, done}, 4'h0);
            wr(`FCW_ADDR_CNT0, 8'h55);
            rd(`FCW_ADDR_CNT0, d);
            check(d, 8'h00);
            rd(8'h50, d);
            check(d, 8'h00);
            wr(`FCW_ADDR_LEN, 8'hff);
            rd(`FCW_ADDR_LEN, d);
            check(d, 8'h3f);
            // Path controls trail a control write by two edges, so look after the read
            wr(`FCW_ADDR_CTRL, 8'h19);
            rd(`FCW_ADDR_CTRL, d);
            check(d, 8'h01);
            check({vco, pll, clken}, 3'b101);
            wr(`FCW_ADDR_CTRL, 8'h21);
            rd(`FCW_ADDR_CTRL, d);
            check(d, 8'h21);
            check({vco, pll, clken}, 3'b011);
            wr(`FCW_ADDR_CTRL, 8'h40);
            rd(`FCW_ADDR_CTRL, d);
            check(d, 8'h00);
            check({vco, pll, clken, done}, 4'h0);
            wr(`FCW_ADDR_CTRL, 8'h80);
            check(done, 1'b1);
            wr(`FCW_ADDR_CTRL, 8'h00);
            check(done, 1'b0);
        end
    endtask

    // One full window on source s with length l
    task t_window(input [5:0] l, input [2:0] s);
        reg [7:0] d;
        reg [23:0] c;
        begin
            src = s;
            wr(`FCW_ADDR_LEN, {2'b00, l});
            wr(`FCW_ADDR_CTRL, {5'h08, s});
            rd(`FCW_ADDR_CTRL, d);
            check(d, {5'h08, s});
            wait_done;
            rd(`FCW_ADDR_CTRL, d);
            check(d, {5'h10, s});
            rd_cnt(c);
            check(c, 24'd4 * n_of(l));
        end
    endtask
    task t_modes;
        integer k;
        begin
            for (k = 1; k <= 6; k = k + 1)
                t_window(k == 6 ? 6'd44 : k[5:0] - 6'd1, k[2:0]);
        end
    endtask

    // Restart in mid-window drops the partial count
    task t_restart;
        reg [23:0] c;
        begin
            src = 3'h1;
            wr(`FCW_ADDR_LEN, 8'h01);
            wr(`FCW_ADDR_CTRL, 8'h41);
            repeat (30) @(posedge clk_sys);
            wr(`FCW_ADDR_CTRL, 8'hc1);
            check(done, 1'b0);
            wait_done;
            rd_cnt(c);
            check(c, 24'd12);
        end
    endtask

    // Pulse mode counts fast rises inside one sensing pulse
    task t_pulse;
        reg [23:0] c;
        begin
            src = 3'h7;
            wr(`FCW_ADDR_CTRL, 8'h47);
            i_src.send_pulse(5);
            wait_done;
            check(done, 1'b1);
            rd_cnt(c);
            check(c, 24'd5);
        end
    endtask

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Main sequence
    initial begin
        mismatches = 0;
        checks_done = 0;
        rst = 1'b1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        src = 3'h0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        t_regs;
        t_modes;
        t_restart;
        t_pulse;
        tally_and_finish;
    end
    // Watchdog, far beyond the several hundred cycles expected
    initial begin
        #1000000;
        mismatches = mismatches + 1;
        tally_and_finish;
    end
endmodule // frequency_counter_window_tb
